/* dsa_pkg.sv */
// constants of the deserializer audio/link control register bank
// assumes a control-bus slave in front that turns frames into register strobes
//
// Overview of operation
// - audio fifo overflow is shown in read-only bit 3 of the audio serial control register.
// - audio fifo underflow is shown in read-only bit 2 of the audio serial control register.
// - writing 1 to bit 1 of the audio serial control register clears the recorded fifo errors.
// - bit 0 of the audio serial control register picks the data strobe edge, 1 rising, 0 falling, reset 0.
// - bit 7 of the pixel clock test register takes the pixel clock from the self test clock pin.
// - with lock mode bit 6 clear, receiver lock shows only while active video arrives.
// - with lock mode bit 6 set, receiver lock shows whenever a serializer is linked.
// - bit 5 of the dual receive register passes the first back-channel pin raw, unfiltered.
// - bits 4-3 pick the link mode: 00 auto, 01 dual, 10 single primary, 11 single secondary.
// - with the second port select set, writes reach port 1 copies and reads return them.
// - with the first port select set, writes reach port 0 copies; reads return them only while the second select is clear.
// - with both selects set, reads return the port 1 copies.
// - after reset the first port select reads 1 and all other dual receive fields read 0.
// - the video-off flag follows the forward channel while control and gpio keep working.
package dsa_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] DSA_AUDIO_CTL_ADDR = 8'h2b;
  localparam logic [7:0] DSA_PCLK_TEST_ADDR = 8'h2e;
  localparam logic [7:0] DSA_DUAL_RX_ADDR = 8'h34;
  localparam logic [7:0] DSA_EQ_CTL1_ADDR = 8'h35;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] DSA_AUDIO_CTL_RST = 8'h00;
  localparam logic [7:0] DSA_PCLK_TEST_RST = 8'h00;
  localparam logic [7:0] DSA_DUAL_RX_RST = 8'h01;
  localparam logic [7:0] DSA_EQ_CTL1_RST = 8'h00;
  localparam logic [7:0] DSA_AUDIO_WR_MASK = 8'hf1;
  localparam logic [7:0] DSA_DUAL_WR_MASK = 8'h7f;
  localparam logic [7:0] DSA_READ_NONE = 8'h00;
  // ==========================================================
  // field positions
  localparam int DSA_AUD_OVF_BIT = 3;
  localparam int DSA_AUD_UNF_BIT = 2;
  localparam int DSA_AUD_CLR_BIT = 1;
  localparam int DSA_AUD_EDGE_BIT = 0;
  localparam int DSA_PCLK_EXT_BIT = 7;
  localparam int DSA_LOCK_MODE_BIT = 6;
  localparam int DSA_RAW_BC_BIT = 5;
  localparam int DSA_MODE_HI_BIT = 4;
  localparam int DSA_MODE_LO_BIT = 3;
  localparam int DSA_P1_SEL_BIT = 1;
  localparam int DSA_P0_SEL_BIT = 0;
  // ==========================================================
  // pin synchroniser lanes and filter depth
  localparam int DSA_NUM_PINS = 7;
  localparam int DSA_PIN_VIDOFF = 0;
  localparam int DSA_PIN_LINKED = 1;
  localparam int DSA_PIN_BC = 2;
  localparam int DSA_PIN_RCLK = 3;
  localparam int DSA_PIN_TCLK = 4;
  localparam int DSA_PIN_ACLK = 5;
  localparam int DSA_PIN_ADATA = 6;
  localparam int DSA_FILT_LEN = 3;
  // ==========================================================
  // receive link modes
  typedef enum logic [1:0] {
    DSA_MODE_AUTO = 2'h0,
    DSA_MODE_DUAL = 2'h1,
    DSA_MODE_SINGLE_PRI = 2'h2,
    DSA_MODE_SINGLE_SEC = 2'h3
  } dsa_link_mode_t;
endpackage : dsa_pkg

/* dsa_cfg_if.sv */
// configuration bits handed from the register bank to its helpers
// assumes one clock domain shared by all users
`timescale 1ns/1ns
interface dsa_cfg_if;
  logic raw_mode;
  logic strobe_rising;
  modport ctl (output raw_mode, output strobe_rising);
  modport use_side (input raw_mode, input strobe_rising);
endinterface : dsa_cfg_if

/* dsa_bc_filter.sv */
// back-channel pin conditioner: raw pass or a majority-free stability filter
// assumes the pin sample is already synchronised to clock_in
`timescale 1ns/1ns
module dsa_bc_filter (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // configuration and data
  dsa_cfg_if.use_side cfg,
  input wire logic sample_in,
  output logic bc_out
);
  import dsa_pkg::*;
  logic [DSA_FILT_LEN-1:0] hist_reg;
  logic [DSA_FILT_LEN-1:0] hist_next;
  logic bc_reg;
  logic bc_next;

  always_comb begin
    hist_next = {hist_reg[DSA_FILT_LEN-2:0], sample_in};
    bc_next = bc_reg;
    if (cfg.raw_mode) begin
      bc_next = sample_in;
    end else if (&hist_reg) begin
      bc_next = 1'b1;
    end else if (~|hist_reg) begin
      bc_next = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hist_reg <= '0;
      bc_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      bc_reg <= bc_next;
    end
  end

  assign bc_out = bc_reg;

  raw_pass_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cfg.raw_mode |=> bc_out == $past(sample_in))
    else $error("raw back channel does not follow the pin");
endmodule : dsa_bc_filter

/* dsa_audio_sampler.sv */
// audio serial data sampler on a selectable bit clock edge
// assumes bit clock and data are synchronised and well below clock_in rate
`timescale 1ns/1ns
module dsa_audio_sampler (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // configuration and pins
  dsa_cfg_if.use_side cfg,
  input wire logic bit_clock_in,
  input wire logic data_in,
  // sampled data
  output logic bit_out,
  output logic valid_out
);
  logic prev_reg;
  logic bit_reg;
  logic bit_next;
  logic valid_reg;
  logic valid_next;
  logic hit;

  always_comb begin
    // both edges are seen one sample late, so data must hold a few cycles
    hit = cfg.strobe_rising ? (bit_clock_in & ~prev_reg) : (~bit_clock_in & prev_reg);
    bit_next = hit ? data_in : bit_reg;
    valid_next = hit;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_reg <= 1'b0;
      bit_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= bit_clock_in;
      bit_reg <= bit_next;
      valid_reg <= valid_next;
    end
  end

  assign bit_out = bit_reg;
  assign valid_out = valid_reg;

  strobe_edge_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    valid_out |-> ($past(cfg.strobe_rising) == $past(bit_clock_in)))
    else $error("audio data strobed on the wrong edge");
endmodule : dsa_audio_sampler

/* dsa_ctrl_regs.sv */
// audio, pixel clock test and dual receive control registers of the deserializer
// assumes single-cycle register strobes from the control-bus slave on clock_in
`timescale 1ns/1ns
module dsa_ctrl_regs (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rd_valid_out,
  // audio fifo events, same clock
  input wire logic audio_overflow_in,
  input wire logic audio_underflow_in,
  // audio serial pins
  input wire logic audio_bit_clock_in,
  input wire logic audio_data_in,
  output logic audio_bit_out,
  output logic audio_bit_valid_out,
  // link status
  input wire logic forward_video_off_in,
  input wire logic serializer_linked_in,
  output logic rx_lock_out,
  output logic video_off_out,
  output dsa_pkg::dsa_link_mode_t receive_link_mode_out,
  // back channel
  input wire logic first_backchannel_pin_in,
  output logic secondary_backchannel_out,
  // pixel clock source
  input wire logic recovered_clock_in,
  input wire logic self_test_clock_input_in,
  output logic pixel_clock_out,
  output logic pixel_clock_external_out,
  // per-port equalizer copies
  output logic [7:0] eq_port0_out,
  output logic [7:0] eq_port1_out
);
  import dsa_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [DSA_NUM_PINS-1:0] pins;
  logic [DSA_NUM_PINS-1:0] sync1_reg;
  logic [DSA_NUM_PINS-1:0] sync2_reg;

  assign pins = {audio_data_in, audio_bit_clock_in, self_test_clock_input_in,
                 recovered_clock_in, first_backchannel_pin_in,
                 serializer_linked_in, forward_video_off_in};

  genvar gi;
  generate
    for (gi = 0; gi < DSA_NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // register state
  logic [7:0] audio_reg;
  logic [7:0] audio_next;
  logic [7:0] pclk_reg;
  logic [7:0] pclk_next;
  logic [7:0] dual_reg;
  logic [7:0] dual_next;
  logic [7:0] eq0_reg;
  logic [7:0] eq0_next;
  logic [7:0] eq1_reg;
  logic [7:0] eq1_next;
  logic wr_audio;
  logic wr_pclk;
  logic wr_dual;
  logic wr_eq;
  logic fifo_clear;

  always_comb begin
    wr_audio = reg_wr_in && (reg_addr_in == DSA_AUDIO_CTL_ADDR);
    wr_pclk = reg_wr_in && (reg_addr_in == DSA_PCLK_TEST_ADDR);
    wr_dual = reg_wr_in && (reg_addr_in == DSA_DUAL_RX_ADDR);
    wr_eq = reg_wr_in && (reg_addr_in == DSA_EQ_CTL1_ADDR);
    fifo_clear = wr_audio && reg_wdata_in[DSA_AUD_CLR_BIT];
    audio_next = audio_reg;
    if (wr_audio) begin
      // the clear bit is an action and always reads back 0
      audio_next = (audio_reg & ~DSA_AUDIO_WR_MASK) | (reg_wdata_in & DSA_AUDIO_WR_MASK);
    end
    if (fifo_clear) begin
      audio_next[DSA_AUD_OVF_BIT] = 1'b0;
      audio_next[DSA_AUD_UNF_BIT] = 1'b0;
    end
    // a new event in the clearing cycle is kept, set beats clear
    if (audio_overflow_in) begin
      audio_next[DSA_AUD_OVF_BIT] = 1'b1;
    end
    if (audio_underflow_in) begin
      audio_next[DSA_AUD_UNF_BIT] = 1'b1;
    end
    pclk_next = wr_pclk ? reg_wdata_in : pclk_reg;
    dual_next = wr_dual ? (reg_wdata_in & DSA_DUAL_WR_MASK) : dual_reg;
    eq0_next = eq0_reg;
    eq1_next = eq1_reg;
    if (wr_eq && dual_reg[DSA_P0_SEL_BIT]) begin
      eq0_next = reg_wdata_in;
    end
    if (wr_eq && dual_reg[DSA_P1_SEL_BIT]) begin
      eq1_next = reg_wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      audio_reg <= DSA_AUDIO_CTL_RST;
      pclk_reg <= DSA_PCLK_TEST_RST;
      dual_reg <= DSA_DUAL_RX_RST;
      eq0_reg <= DSA_EQ_CTL1_RST;
      eq1_reg <= DSA_EQ_CTL1_RST;
    end else begin
      audio_reg <= audio_next;
      pclk_reg <= pclk_next;
      dual_reg <= dual_next;
      eq0_reg <= eq0_next;
      eq1_reg <= eq1_next;
    end
  end

  // ==========================================================
  // read path
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [7:0] eq_view;

  always_comb begin
    // port 1 wins when both selects are set; software must drop it for port 0
    if (dual_reg[DSA_P1_SEL_BIT]) begin
      eq_view = eq1_reg;
    end else if (dual_reg[DSA_P0_SEL_BIT]) begin
      eq_view = eq0_reg;
    end else begin
      eq_view = DSA_READ_NONE;
    end
    rvalid_next = reg_rd_in;
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        DSA_AUDIO_CTL_ADDR: rdata_next = audio_reg;
        DSA_PCLK_TEST_ADDR: rdata_next = pclk_reg;
        DSA_DUAL_RX_ADDR: rdata_next = dual_reg;
        DSA_EQ_CTL1_ADDR: rdata_next = eq_view;
        default: rdata_next = DSA_READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= DSA_READ_NONE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rd_valid_out = rvalid_reg;

  // ==========================================================
  // link status, pixel clock and mode outputs
  logic lock_reg;
  logic lock_next;
  logic vidoff_reg;
  logic vidoff_next;
  logic pix_reg;
  logic pix_next;
  logic pext_reg;
  logic pext_next;
  dsa_link_mode_t mode_reg;
  dsa_link_mode_t mode_next;
  logic linked_s;
  logic vidoff_s;

  always_comb begin
    linked_s = sync2_reg[DSA_PIN_LINKED];
    vidoff_s = sync2_reg[DSA_PIN_VIDOFF];
    // video-off gates lock only while lock mode bit 6 is clear, and drives video_off_out; control and gpio stay up
    vidoff_next = vidoff_s;
    if (dual_reg[DSA_LOCK_MODE_BIT]) begin
      lock_next = linked_s;
    end else begin
      lock_next = linked_s & ~vidoff_s;
    end
    pext_next = pclk_reg[DSA_PCLK_EXT_BIT];
    // sampled clock select: only for slow test clocks, not a glitch-free mux
    pix_next = pclk_reg[DSA_PCLK_EXT_BIT] ? sync2_reg[DSA_PIN_TCLK]
                                          : sync2_reg[DSA_PIN_RCLK];
    mode_next = dsa_link_mode_t'(dual_reg[DSA_MODE_HI_BIT:DSA_MODE_LO_BIT]);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_reg <= 1'b0;
      vidoff_reg <= 1'b0;
      pix_reg <= 1'b0;
      pext_reg <= 1'b0;
      mode_reg <= DSA_MODE_AUTO;
    end else begin
      lock_reg <= lock_next;
      vidoff_reg <= vidoff_next;
      pix_reg <= pix_next;
      pext_reg <= pext_next;
      mode_reg <= mode_next;
    end
  end

  assign rx_lock_out = lock_reg;
  assign video_off_out = vidoff_reg;
  assign pixel_clock_out = pix_reg;
  assign pixel_clock_external_out = pext_reg;
  assign receive_link_mode_out = mode_reg;
  assign eq_port0_out = eq0_reg;
  assign eq_port1_out = eq1_reg;

  // ==========================================================
  // helpers
  dsa_cfg_if cfg ();
  assign cfg.raw_mode = dual_reg[DSA_RAW_BC_BIT];
  assign cfg.strobe_rising = audio_reg[DSA_AUD_EDGE_BIT];

  dsa_bc_filter u_bc (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .cfg(cfg),
    .sample_in(sync2_reg[DSA_PIN_BC]),
    .bc_out(secondary_backchannel_out)
  );

  dsa_audio_sampler u_aud (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .cfg(cfg),
    .bit_clock_in(sync2_reg[DSA_PIN_ACLK]),
    .data_in(sync2_reg[DSA_PIN_ADATA]),
    .bit_out(audio_bit_out),
    .valid_out(audio_bit_valid_out)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence clear_write_s;
    fifo_clear && !audio_overflow_in;
  endsequence

  ovf_set_a: assert property (audio_overflow_in |=> audio_reg[DSA_AUD_OVF_BIT])
    else $error("overflow event not recorded");
  unf_set_a: assert property (audio_underflow_in |=> audio_reg[DSA_AUD_UNF_BIT])
    else $error("underflow event not recorded");
  fifo_clear_a: assert property (clear_write_s |=> !audio_reg[DSA_AUD_OVF_BIT])
    else $error("fifo error not cleared");
  flag_sticky_a: assert property (audio_reg[DSA_AUD_UNF_BIT] && !fifo_clear
    |=> audio_reg[DSA_AUD_UNF_BIT])
    else $error("underflow flag dropped without a clear");
  lock_video_a: assert property (!dual_reg[DSA_LOCK_MODE_BIT] && vidoff_s
    && $stable(dual_reg) |=> !rx_lock_out)
    else $error("lock shown without active video");
  lock_link_a: assert property (dual_reg[DSA_LOCK_MODE_BIT] && linked_s
    && $stable(dual_reg) |=> rx_lock_out)
    else $error("lock missing while linked");
  // a write in the read cycle changes the copy, so compare with the copy the read saw
  port_read_a: assert property (reg_rd_in && reg_addr_in == DSA_EQ_CTL1_ADDR
    && dual_reg[DSA_P1_SEL_BIT] |=> reg_rd_valid_out && reg_rdata_out == $past(eq1_reg))
    else $error("port 1 copy not returned");
  port0_write_a: assert property (wr_eq && dual_reg[DSA_P0_SEL_BIT]
    |=> eq0_reg == $past(reg_wdata_in))
    else $error("port 0 copy not written");
  // the mode output is registered, so it trails the field by one cycle
  mode_out_a: assert property ($changed(dual_reg)
    |=> receive_link_mode_out == $past(dual_reg[DSA_MODE_HI_BIT:DSA_MODE_LO_BIT]))
    else $error("link mode output does not follow field");
  sel_reset_a: assert property ($rose(rst_b_in) |-> dual_reg == DSA_DUAL_RX_RST)
    else $error("dual receive reset value wrong");
endmodule : dsa_ctrl_regs

/* dsa_ser_model.sv */
// far-side serializer model: link status pins, recovered and test clocks, audio stream
// assumes the bench steers link_up_in and video_on_in between clock edges
`timescale 1ns/1ns
module dsa_ser_model (
  // clock
  input wire logic clock_in,
  // scenario controls
  input wire logic link_up_in,
  input wire logic video_on_in,
  // link side pins
  output logic video_off_out,
  output logic linked_out,
  output logic rclk_out,
  output logic tclk_out,
  output logic abclk_out,
  output logic adata_out
);
  logic [3:0] phase_reg = 4'h0;
  logic [1:0] tph_reg = 2'h0;
  logic tclk_reg = 1'h0;
  // ==========================================================
  // phase counters; test clock period 6, recovered clock 16, so the source is visible
  always @(posedge clock_in) begin
    phase_reg <= phase_reg + 4'h1;
    tph_reg <= (tph_reg == 2'h2) ? 2'h0 : tph_reg + 2'h1;
    if (tph_reg == 2'h2) begin
      tclk_reg <= ~tclk_reg;
    end
  end
  // ==========================================================
  // pins; audio clock stands still without a link, data then churns every cycle
  assign video_off_out = ~video_on_in;
  assign linked_out = link_up_in;
  assign rclk_out = phase_reg[3];
  assign tclk_out = tclk_reg;
  assign abclk_out = link_up_in & ~phase_reg[3];
  // data is 0 around the rising edge and 1 around the falling edge
  assign adata_out = link_up_in ? (phase_reg >= 4'h4 && phase_reg <= 4'hb) : phase_reg[0];
endmodule : dsa_ser_model

/* deserializer_audio_link_ctrl_regs_test.sv */
// self-checking bench for the audio/link control register bank
// assumes the design package, interface and helper modules are compiled first
`timescale 1ns/1ns
module deserializer_audio_link_ctrl_regs_test;
  import dsa_pkg::*;
  logic clock_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic ovf = 1'h0;
  logic unf = 1'h0;
  logic bc_pin = 1'h0;
  logic link_up = 1'h0;
  logic video_on = 1'h0;
  logic vid_off, linked, rclk, tclk, abclk, adata, last;
  logic rd_valid, abit, avalid, lock, voff, bc_out, pclk, pext;
  logic [7:0] rdata, eq0, eq1;
  dsa_link_mode_t mode_out;
  int n_errors = 0;
  int tests_run = 0;
  int i, cnt;
  always #2 clock_in = ~clock_in;
  dsa_ser_model ser (.clock_in(clock_in), .link_up_in(link_up), .video_on_in(video_on),
    .video_off_out(vid_off), .linked_out(linked), .rclk_out(rclk), .tclk_out(tclk),
    .abclk_out(abclk), .adata_out(adata));
  dsa_ctrl_regs uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rd_valid_out(rd_valid), .audio_overflow_in(ovf), .audio_underflow_in(unf),
    .audio_bit_clock_in(abclk), .audio_data_in(adata), .audio_bit_out(abit),
    .audio_bit_valid_out(avalid), .forward_video_off_in(vid_off),
    .serializer_linked_in(linked), .rx_lock_out(lock), .video_off_out(voff),
    .receive_link_mode_out(mode_out), .first_backchannel_pin_in(bc_pin),
    .secondary_backchannel_out(bc_out), .recovered_clock_in(rclk),
    .self_test_clock_input_in(tclk), .pixel_clock_out(pclk),
    .pixel_clock_external_out(pext), .eq_port0_out(eq0), .eq_port1_out(eq1));
  // ==========================================================
  // access and compare tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask : wt
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clock_in);
    wr = 1'h0;
  endtask : wr_reg
  // read answer is registered on the strobe edge, checked at the next falling edge
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    addr = a;
    rd = 1'h1;
    @(negedge clock_in);
    rd = 1'h0;
    chk_bit(rd_valid, 1'h1, "read valid");
    chk_byte(rdata, exp, "read data");
  endtask : rd_reg
  task automatic ev(input logic o, input logic u);
    @(negedge clock_in);
    ovf = o;
    unf = u;
    @(negedge clock_in);
    ovf = 1'h0;
    unf = 1'h0;
  endtask : ev
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #40000;
    n_errors++;
    $display("mismatch at %0t: run limit reached", $time);
    close_out();
  end
  // ==========================================================
  // scenarios
  initial begin
    wt(4);
    rst_b_in = 1'h1;
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'h00);
    rd_reg(DSA_PCLK_TEST_ADDR, 8'h00);
    rd_reg(DSA_DUAL_RX_ADDR, 8'h01);
    rd_reg(DSA_EQ_CTL1_ADDR, 8'h00);
    rd_reg(8'h40, 8'h00);
    $display("test reset values done");
    wr_reg(DSA_AUDIO_CTL_ADDR, 8'hff);
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'hf1);
    ev(1'h1, 1'h0);
    wt(20);
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'hf9);
    ev(1'h0, 1'h1);
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'hfd);
    wr_reg(DSA_AUDIO_CTL_ADDR, 8'hf3);
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'hf1);
    $display("test fifo flags done");
    link_up = 1'h1;
    for (i = 0; i < 2; i++) begin
      wr_reg(DSA_AUDIO_CTL_ADDR, {7'h00, i[0]});
      wt(20);
      cnt = 0;
      repeat (64) begin
        @(negedge clock_in);
        if (avalid === 1'h1) begin
          cnt++;
          chk_bit(abit, ~i[0], "audio bit");
        end
      end
      chk_bit(cnt > 0, 1'h1, "audio strobes");
    end
    $display("test audio edge done");
    // lock mode in bit 6, video on or off; port 0 select kept
    for (i = 0; i < 4; i++) begin
      wr_reg(DSA_DUAL_RX_ADDR, {1'h0, i[1], 6'h01});
      video_on = i[0];
      wt(6);
      chk_bit(lock, i[1] | i[0], "receiver lock");
      chk_bit(voff, ~i[0], "video off flag");
    end
    link_up = 1'h0;
    wt(6);
    chk_bit(lock, 1'h0, "lock without link");
    link_up = 1'h1;
    $display("test lock done");
    for (i = 0; i < 4; i++) begin
      wr_reg(DSA_DUAL_RX_ADDR, {3'h0, i[1:0], 3'h1});
      wt(1);
      chk_byte({6'h00, mode_out}, {6'h00, i[1:0]}, "link mode");
      rd_reg(DSA_DUAL_RX_ADDR, {3'h0, i[1:0], 3'h1});
    end
    wr_reg(DSA_DUAL_RX_ADDR, 8'hff);
    rd_reg(DSA_DUAL_RX_ADDR, 8'h7f);
    $display("test link mode done");
    wr_reg(DSA_EQ_CTL1_ADDR, 8'h5a);
    wr_reg(DSA_DUAL_RX_ADDR, 8'h02);
    wr_reg(DSA_EQ_CTL1_ADDR, 8'h3c);
    chk_byte(eq1, 8'h3c, "port 1 copy");
    chk_byte(eq0, 8'h5a, "port 0 copy");
    rd_reg(DSA_EQ_CTL1_ADDR, 8'h3c);
    wr_reg(DSA_PCLK_TEST_ADDR, 8'h15);
    rd_reg(DSA_PCLK_TEST_ADDR, 8'h15);
    wr_reg(DSA_DUAL_RX_ADDR, 8'h03);
    rd_reg(DSA_EQ_CTL1_ADDR, 8'h3c);
    wr_reg(DSA_DUAL_RX_ADDR, 8'h01);
    rd_reg(DSA_EQ_CTL1_ADDR, 8'h5a);
    wr_reg(DSA_EQ_CTL1_ADDR, 8'h99);
    chk_byte(eq0, 8'h99, "port 0 copy");
    chk_byte(eq1, 8'h3c, "port 1 copy");
    rd_reg(DSA_PCLK_TEST_ADDR, 8'h15);
    // no select: the per-port write lands nowhere and the read returns zero
    wr_reg(DSA_DUAL_RX_ADDR, 8'h00);
    wr_reg(DSA_EQ_CTL1_ADDR, 8'h77);
    chk_byte(eq0, 8'h99, "port 0 copy kept");
    chk_byte(eq1, 8'h3c, "port 1 copy kept");
    rd_reg(DSA_EQ_CTL1_ADDR, 8'h00);
    wr_reg(DSA_DUAL_RX_ADDR, 8'h01);
    $display("test port select done");
    for (i = 0; i < 2; i++) begin
      wr_reg(DSA_PCLK_TEST_ADDR, {i[0], 7'h00});
      wt(6);
      chk_bit(pext, i[0], "clock source flag");
      cnt = 0;
      last = pclk;
      repeat (48) begin
        @(negedge clock_in);
        if (pclk !== last) cnt++;
        last = pclk;
      end
      chk_bit(cnt > 10, i[0], "pixel clock rate");
    end
    $display("test pixel clock done");
    // a one-cycle glitch passes only in raw mode, the filter swallows it
    for (i = 0; i < 2; i++) begin
      wr_reg(DSA_DUAL_RX_ADDR, {2'h0, i[0], 5'h01});
      wt(8);
      bc_pin = 1'h1;
      wt(1);
      bc_pin = 1'h0;
      cnt = 0;
      repeat (10) begin
        @(negedge clock_in);
        if (bc_out === 1'h1) cnt++;
      end
      chk_bit(cnt > 0, i[0], "back channel glitch");
      bc_pin = 1'h1;
      wt(10);
      chk_bit(bc_out, 1'h1, "back channel level");
      bc_pin = 1'h0;
    end
    $display("test back channel done");
    rst_b_in = 1'h0;
    wt(2);
    rst_b_in = 1'h1;
    rd_reg(DSA_DUAL_RX_ADDR, 8'h01);
    rd_reg(DSA_AUDIO_CTL_ADDR, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule : deserializer_audio_link_ctrl_regs_test
